// [dv/core_irq_model.sv]
// Behavioural model of the processor core and the interrupt request logic.
`timescale 1ns/100ps
module core_irq_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Core control from the block
    input wire logic coreHalt,
    input wire logic coreReset,
    // Stimulus from the bench
    input wire logic [power_mode_pkg::NUM_IRQ-1:0] irqRaise,
    input wire logic [power_mode_pkg::NUM_IRQ-1:0] irqMask,
    // Towards the block
    output logic instrDone,
    output logic [power_mode_pkg::NUM_IRQ-1:0] intPending,
    output logic [power_mode_pkg::NUM_IRQ-1:0] intEnable
);
    logic phase;
    // Every instruction takes two cycles, so a mode write never meets a one-byte follower.
    always_ff @(posedge mclk) begin
        phase <= (rst || coreHalt || coreReset) ? 1'b0 : !phase;
    end
    // The clock source is taken to be the internal oscillator before any stop request.
    assign instrDone = phase;
    // A running core services what is pending at once; a halted one lets requests pile up.
    always_ff @(posedge mclk) begin
        intPending <= (rst || coreReset || !coreHalt) ? '0 : (intPending | irqRaise);
        intEnable <= rst ? '0 : irqMask;
    end
endmodule : core_irq_model

// [dv/power_mode_control_tb.sv]
// Self-checking testbench of the power-mode controller.
`timescale 1ns/100ps
module power_mode_control_tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    power_mode_pkg::apb_req_t apbReq = '0;
    power_mode_pkg::apb_rsp_t apbRsp;
    power_mode_pkg::reset_src_t resetSrc = '0;
    logic instrDone, coreHalt, coreReset, intrInactive, oscStop, regulatorOff;
    logic [15:0] restartAddr;
    logic [7:0] intPending, intEnable, periphClkEn;
    logic [7:0] irqRaise = 8'h00;
    logic [7:0] irqMask = 8'h00;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int checks = 0;

    always #2 mclk = !mclk;

    power_mode_control dut_u (.mclk(mclk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
        .instrDone(instrDone), .coreHalt(coreHalt), .coreReset(coreReset),
        .restartAddr(restartAddr), .intPending(intPending), .intEnable(intEnable),
        .intrInactive(intrInactive), .resetSrc(resetSrc), .oscStop(oscStop),
        .regulatorOff(regulatorOff), .periphClkEn(periphClkEn));
    core_irq_model core_u (.mclk(mclk), .rst(rst), .coreHalt(coreHalt), .coreReset(coreReset),
        .irqRaise(irqRaise), .irqMask(irqMask), .instrDone(instrDone),
        .intPending(intPending), .intEnable(intEnable));

    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic fail_out(input string what);
        num_errors++;
        $display("mismatch %s expected done seen timeout", what);
        print_verdict();
    endtask : fail_out

    // Called just after a rising edge; an idle cycle follows so two requests never collide.
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge mclk);
        apbReq.penable <= 1'b1;
        for (int n = 0; n < 20; n++) begin
            @(posedge mclk);
            if (apbRsp.pready === 1'b1) begin
                rd = apbRsp.prdata;
                err = apbRsp.pslverr;
                apbReq <= '0;
                @(posedge mclk);
                return;
            end
        end
        fail_out("pready");
    endtask : apb

    task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp, input string what);
        apb(1'b0, addr, '0);
        chk(what, exp, rd);
    endtask : rdchk

    task automatic wait_halt(input logic lvl, input string what);
        for (int n = 0; n < 40; n++) begin
            if (coreHalt === lvl) return;
            @(posedge mclk);
        end
        fail_out(what);
    endtask : wait_halt

    // The source is sampled at the first edge, so the sequence already shows after it.
    task automatic pulse_src(input logic [3:0] m);
        resetSrc <= power_mode_pkg::reset_src_t'(m);
        @(posedge mclk);
        resetSrc <= '0;
        @(posedge mclk);
    endtask : pulse_src

    task automatic t_reset();
        wait_halt(1'b0, "reset sequence");
        chk("restartAddr", '0, {16'h0000, restartAddr});
        chk("periphClkEn", 32'h0000_00FF, {24'h00_0000, periphClkEn});
        rdchk(power_mode_pkg::OFS_POWER_MODE, '0, "power reset");
        rdchk(power_mode_pkg::OFS_REGULATOR, '0, "regulator reset");
    endtask : t_reset

    task automatic t_regs();
        apb(1'b1, power_mode_pkg::OFS_POWER_MODE, 32'hFFFF_FFFC);
        rdchk(power_mode_pkg::OFS_POWER_MODE, 32'h0000_00FC, "flags");
        apb(1'b1, power_mode_pkg::OFS_REGULATOR, 32'hFFFF_FFFF);
        rdchk(power_mode_pkg::OFS_REGULATOR, 32'h0000_0008, "regulator");
        apb(1'b1, power_mode_pkg::OFS_REGULATOR, '0);
        apb(1'b1, power_mode_pkg::OFS_PERIPH_CLK, 32'h0000_00A5);
        // The enables follow the register one edge later, so let that edge pass first.
        @(posedge mclk);
        chk("gated clocks", 32'h0000_00A5, {24'h00_0000, periphClkEn});
        apb(1'b1, power_mode_pkg::OFS_PERIPH_CLK, 32'h0000_00FF);
        apb(1'b0, 8'h40, '0);
        chk("pslverr", 32'h0000_0001, {31'h0, err});
    endtask : t_regs

    task automatic t_idle();
        apb(1'b1, power_mode_pkg::OFS_POWER_MODE, 32'h0000_00FD);
        wait_halt(1'b1, "idle entry");
        chk("oscStop idle", '0, {31'h0, oscStop});
        chk("intrInactive idle", '0, {31'h0, intrInactive});
        chk("clocks idle", 32'h0000_00FF, {24'h00_0000, periphClkEn});
        rdchk(power_mode_pkg::OFS_POWER_MODE, 32'h0000_00FC, "idle read");
        rdchk(power_mode_pkg::OFS_STATUS, 32'h0000_0005, "status idle");
        irqRaise <= 8'h04;
        @(posedge mclk);
        irqRaise <= 8'h00;
        repeat (6) @(posedge mclk);
        chk("masked irq", 32'h0000_0001, {31'h0, coreHalt});
        irqMask <= 8'h04;
        @(posedge mclk);
        wait_halt(1'b0, "idle wake");
        rdchk(power_mode_pkg::OFS_POWER_MODE, 32'h0000_00FC, "after wake");
        chk("stay awake", '0, {30'h0, coreHalt, coreReset});
        irqMask <= 8'h00;
        apb(1'b1, power_mode_pkg::OFS_POWER_MODE, 32'h0000_0001);
        wait_halt(1'b1, "idle again");
        pulse_src(4'b0100);
        chk("watchdog in idle", 32'h0000_0001, {31'h0, coreReset});
        wait_halt(1'b0, "idle reset exit");
        rdchk(power_mode_pkg::OFS_POWER_MODE, '0, "cleared by reset");
    endtask : t_idle

    task automatic t_stop(input logic cfg, input logic [3:0] m, input logic expRst);
        apb(1'b1, power_mode_pkg::OFS_REGULATOR, {28'h000_0000, cfg, 3'b000});
        apb(1'b1, power_mode_pkg::OFS_POWER_MODE, 32'h0000_0002);
        wait_halt(1'b1, "stop entry");
        chk("oscStop", 32'h0000_0001, {31'h0, oscStop});
        chk("intrInactive", 32'h0000_0001, {31'h0, intrInactive});
        chk("clocks stop", '0, {24'h00_0000, periphClkEn});
        chk("regulatorOff", {31'h0, cfg}, {31'h0, regulatorOff});
        rdchk(power_mode_pkg::OFS_STATUS, 32'h0000_0002, "status stop");
        irqMask <= 8'hFF;
        irqRaise <= 8'h01;
        @(posedge mclk);
        irqRaise <= 8'h00;
        repeat (6) @(posedge mclk);
        chk("irq in stop", 32'h0000_0002, {30'h0, coreHalt, coreReset});
        pulse_src(m);
        chk("source reset", {31'h0, expRst}, {31'h0, coreReset});
        if (!expRst) begin
            pulse_src(4'b1000);
            chk("pin reset", 32'h0000_0001, {31'h0, coreReset});
        end
        irqMask <= 8'h00;
        wait_halt(1'b0, "stop exit");
        chk("restart", '0, {16'h0000, restartAddr});
    endtask : t_stop

    initial begin
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        t_reset();
        t_regs();
        t_idle();
        t_stop(1'b0, 4'b0010, 1'b1);
        t_stop(1'b0, 4'b0100, 1'b1);
        t_stop(1'b0, 4'b0001, 1'b1);
        t_stop(1'b1, 4'b0100, 1'b0);
        t_stop(1'b1, 4'b0010, 1'b0);
        t_stop(1'b1, 4'b1000, 1'b1);
        print_verdict();
    end
endmodule : power_mode_control_tb

// [rtl/power_mode_control.sv]
// Power-mode controller: idle and stop entry, exit and reset sequencing over APB.
`timescale 1ns/100ps
module power_mode_control (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Register bus
    input wire power_mode_pkg::apb_req_t apbReq,
    output power_mode_pkg::apb_rsp_t apbRsp,
    // Processor core
    input wire logic instrDone,
    output logic coreHalt,
    output logic coreReset,
    output logic [15:0] restartAddr,
    // Interrupt logic
    input wire logic [power_mode_pkg::NUM_IRQ-1:0] intPending,
    input wire logic [power_mode_pkg::NUM_IRQ-1:0] intEnable,
    output logic intrInactive,
    // Reset sources
    input wire power_mode_pkg::reset_src_t resetSrc,
    // Clock and power control
    output logic oscStop,
    output logic regulatorOff,
    output logic [power_mode_pkg::NUM_PERIPH-1:0] periphClkEn
);

    power_mode_pkg::mode_t mode;
    power_mode_pkg::mode_t next_mode;
    logic idleSel;
    logic stopSel;
    logic [power_mode_pkg::FLAGS_W-1:0] generalFlags;
    logic stopRegulatorCfg;
    logic [power_mode_pkg::NUM_PERIPH-1:0] periphClkReg;
    logic [power_mode_pkg::CNT_W-1:0] seqCount;
    logic wakeReq;
    logic resetHit;
    logic wrAccess;
    logic rdSetup;
    logic enterIdle;
    logic enterStop;
    logic [power_mode_pkg::DATA_W-1:0] next_rdata;

    function automatic logic hitsOffset(input logic [power_mode_pkg::ADDR_W-1:0] addr,
                                        input logic [power_mode_pkg::ADDR_W-1:0] ofs);
        hitsOffset = (addr == ofs);
    endfunction : hitsOffset

    function automatic logic isMapped(input logic [power_mode_pkg::ADDR_W-1:0] addr);
        isMapped = hitsOffset(addr, power_mode_pkg::OFS_POWER_MODE)
            || hitsOffset(addr, power_mode_pkg::OFS_REGULATOR)
            || hitsOffset(addr, power_mode_pkg::OFS_PERIPH_CLK)
            || hitsOffset(addr, power_mode_pkg::OFS_STATUS);
    endfunction : isMapped

    wake_qualify u_wake (
        .intPending(intPending),
        .intEnable(intEnable),
        .resetSrc(resetSrc),
        .inStop(mode == power_mode_pkg::MODE_STOP),
        .stopRegulatorCfg(stopRegulatorCfg),
        .wakeReq(wakeReq),
        .resetHit(resetHit)
    );

    assign wrAccess = apbReq.psel && apbReq.penable && apbRsp.pready && apbReq.pwrite;
    assign rdSetup = apbReq.psel && !apbReq.penable;
    assign enterStop = (mode == power_mode_pkg::MODE_RUN) && stopSel && instrDone;
    assign enterIdle = (mode == power_mode_pkg::MODE_RUN) && idleSel && !stopSel && instrDone;

    // Mode sequencing. A reset request outranks every other event.
    always_comb begin
        next_mode = mode;
        case (mode)
            power_mode_pkg::MODE_RUN: begin
                if (resetHit) begin
                    next_mode = power_mode_pkg::MODE_RESET;
                end else if (enterStop) begin
                    next_mode = power_mode_pkg::MODE_STOP;
                end else if (enterIdle) begin
                    next_mode = power_mode_pkg::MODE_IDLE;
                end
            end
            power_mode_pkg::MODE_IDLE: begin
                if (resetHit) begin
                    next_mode = power_mode_pkg::MODE_RESET;
                end else if (wakeReq) begin
                    next_mode = power_mode_pkg::MODE_RUN;
                end
            end
            power_mode_pkg::MODE_STOP: begin
                // Interrupt requests are deliberately not looked at here.
                if (resetHit) begin
                    next_mode = power_mode_pkg::MODE_RESET;
                end
            end
            power_mode_pkg::MODE_RESET: begin
                if (resetHit) begin
                    next_mode = power_mode_pkg::MODE_RESET;
                end else if (seqCount == '0) begin
                    next_mode = power_mode_pkg::MODE_RUN;
                end
            end
            default: begin
                next_mode = power_mode_pkg::MODE_RESET;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            mode <= power_mode_pkg::MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    // Reset sequence length; a fresh request restarts the count.
    always_ff @(posedge mclk) begin
        if (rst || resetHit) begin
            seqCount <= power_mode_pkg::CNT_W'(power_mode_pkg::RESET_SEQ_CYCLES - 1);
        end else if (mode == power_mode_pkg::MODE_RESET && seqCount != '0) begin
            seqCount <= seqCount - 1'b1;
        end
    end

    // Mode select bits. An interrupt wake clears idle select in the same edge.
    always_ff @(posedge mclk) begin
        if (rst || next_mode == power_mode_pkg::MODE_RESET) begin
            idleSel <= 1'b0;
            stopSel <= 1'b0;
        end else begin
            if (mode == power_mode_pkg::MODE_IDLE && wakeReq) begin
                idleSel <= 1'b0;
            end else if (wrAccess && hitsOffset(apbReq.paddr, power_mode_pkg::OFS_POWER_MODE)
                         && apbReq.pwdata[power_mode_pkg::IDLE_BIT]) begin
                idleSel <= 1'b1;
            end
            if (wrAccess && hitsOffset(apbReq.paddr, power_mode_pkg::OFS_POWER_MODE)
                && apbReq.pwdata[power_mode_pkg::STOP_BIT]) begin
                stopSel <= 1'b1;
            end else if (enterStop) begin
                stopSel <= 1'b0;
            end
        end
    end

    // Software registers. Idle keeps them; only a device reset clears them.
    always_ff @(posedge mclk) begin
        if (rst || next_mode == power_mode_pkg::MODE_RESET) begin
            generalFlags <= power_mode_pkg::FLAGS_RESET;
            stopRegulatorCfg <= power_mode_pkg::STOP_REGULATOR_CFG_RESET;
            periphClkReg <= power_mode_pkg::PERIPH_CLK_RESET;
        end else if (wrAccess) begin
            if (hitsOffset(apbReq.paddr, power_mode_pkg::OFS_POWER_MODE)) begin
                generalFlags <= apbReq.pwdata[power_mode_pkg::FLAGS_LSB +: power_mode_pkg::FLAGS_W];
            end
            if (hitsOffset(apbReq.paddr, power_mode_pkg::OFS_REGULATOR)) begin
                stopRegulatorCfg <= apbReq.pwdata[power_mode_pkg::STOP_REGULATOR_CFG_BIT];
            end
            if (hitsOffset(apbReq.paddr, power_mode_pkg::OFS_PERIPH_CLK)) begin
                periphClkReg <= apbReq.pwdata[power_mode_pkg::NUM_PERIPH-1:0];
            end
        end
    end

    always_comb begin
        next_rdata = '0;
        case (apbReq.paddr)
            power_mode_pkg::OFS_POWER_MODE: begin
                // Both select bits read as zero whatever was written.
                next_rdata[power_mode_pkg::FLAGS_LSB +: power_mode_pkg::FLAGS_W] = generalFlags;
            end
            power_mode_pkg::OFS_REGULATOR: begin
                next_rdata[power_mode_pkg::STOP_REGULATOR_CFG_BIT] = stopRegulatorCfg;
            end
            power_mode_pkg::OFS_PERIPH_CLK: begin
                next_rdata[power_mode_pkg::NUM_PERIPH-1:0] = periphClkReg;
            end
            power_mode_pkg::OFS_STATUS: begin
                next_rdata[1:0] = mode;
                next_rdata[2] = idleSel;
                next_rdata[3] = stopSel;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    // Every access completes with one access cycle; unmapped ones flag an error.
    always_ff @(posedge mclk) begin
        if (rst) begin
            apbRsp <= '0;
        end else begin
            apbRsp.pready <= rdSetup;
            apbRsp.pslverr <= rdSetup && !isMapped(apbReq.paddr);
            apbRsp.prdata <= (rdSetup && !apbReq.pwrite) ? next_rdata : '0;
        end
    end

    // Core and power outputs follow the next mode so they line up with it.
    always_ff @(posedge mclk) begin
        if (rst) begin
            coreHalt <= 1'b1;
            coreReset <= 1'b1;
            restartAddr <= power_mode_pkg::RESTART_ADDR;
            intrInactive <= 1'b1;
            oscStop <= 1'b0;
            regulatorOff <= 1'b0;
            periphClkEn <= '0;
        end else begin
            coreHalt <= (next_mode != power_mode_pkg::MODE_RUN);
            coreReset <= (next_mode == power_mode_pkg::MODE_RESET);
            restartAddr <= power_mode_pkg::RESTART_ADDR;
            intrInactive <= (next_mode == power_mode_pkg::MODE_STOP)
                || (next_mode == power_mode_pkg::MODE_RESET);
            oscStop <= (next_mode == power_mode_pkg::MODE_STOP);
            regulatorOff <= (next_mode == power_mode_pkg::MODE_STOP) && stopRegulatorCfg;
            if (next_mode == power_mode_pkg::MODE_STOP || next_mode == power_mode_pkg::MODE_RESET) begin
                periphClkEn <= '0;
            end else begin
                // Idle leaves the peripheral gating exactly as software set it.
                periphClkEn <= periphClkReg;
            end
        end
    end

    idle_entry_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_RUN && idleSel && !stopSel && instrDone && !resetHit)
        |=> (mode == power_mode_pkg::MODE_IDLE) && coreHalt)
        else $error("idle not entered after the writing instruction");

    stop_entry_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_RUN && stopSel && instrDone && !resetHit)
        |=> (mode == power_mode_pkg::MODE_STOP) && coreHalt && oscStop)
        else $error("stop not entered after the writing instruction");

    idle_keeps_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_IDLE) |-> !oscStop && !intrInactive
        && (periphClkEn == periphClkReg))
        else $error("idle disturbed clocks or peripherals");

    idle_wake_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_IDLE && |(intPending & intEnable) && !resetHit)
        |=> !coreHalt && !coreReset && !idleSel)
        else $error("enabled interrupt did not wake idle");

    stop_gated_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_STOP) |-> oscStop && intrInactive && (periphClkEn == '0))
        else $error("stop left clocks or interrupts running");

    stop_no_int_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_STOP && resetSrc == '0) |=> $stable(mode) && coreHalt)
        else $error("stop ended without a reset");

    cfg_pin_only_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_STOP && stopRegulatorCfg && !resetSrc.extPin)
        |=> (mode == power_mode_pkg::MODE_STOP) && regulatorOff)
        else $error("stop with regulator off ended by a non-pin reset");

    cfg_any_src_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_STOP && !stopRegulatorCfg && resetSrc.clockLoss)
        |=> coreReset && !regulatorOff)
        else $error("clock-loss reset did not end stop");

    reset_seq_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(coreReset) |-> coreReset[*8] ##0 (restartAddr == power_mode_pkg::RESTART_ADDR))
        else $error("reset sequence too short");

    sel_read_zero_a: assert property (@(posedge mclk) disable iff (rst)
        (apbRsp.pready && !apbReq.pwrite && apbReq.paddr == power_mode_pkg::OFS_POWER_MODE)
        |-> (apbRsp.prdata[power_mode_pkg::STOP_BIT:power_mode_pkg::IDLE_BIT] == 2'b00))
        else $error("select bits read back non-zero");

    idle_regs_keep_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_IDLE && !resetHit && !wrAccess)
        |=> $stable(generalFlags) && $stable(stopRegulatorCfg) && $stable(periphClkReg))
        else $error("idle lost register contents");

    wdog_idle_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_IDLE && resetSrc.watchdog) |=> coreReset && coreHalt)
        else $error("watchdog did not end idle");

    reset_exit_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_RESET && !resetHit && seqCount == '0)
        |=> (mode == power_mode_pkg::MODE_RUN) && !coreReset && !coreHalt)
        else $error("reset sequence did not restart the core");

    reg_off_stop_a: assert property (@(posedge mclk) disable iff (rst)
        regulatorOff |-> (mode == power_mode_pkg::MODE_STOP))
        else $error("regulator off outside stop");

    reg_read_zero_a: assert property (@(posedge mclk) disable iff (rst)
        (apbRsp.pready && !apbReq.pwrite && apbReq.paddr == power_mode_pkg::OFS_REGULATOR)
        |-> (apbRsp.prdata[power_mode_pkg::DATA_W-1:power_mode_pkg::STOP_REGULATOR_CFG_BIT+1] == '0)
        && (apbRsp.prdata[power_mode_pkg::STOP_REGULATOR_CFG_BIT-1:0] == '0))
        else $error("reserved regulator bits read non-zero");

    periph_gate_a: assert property (@(posedge mclk) disable iff (rst)
        (mode == power_mode_pkg::MODE_RUN && next_mode == power_mode_pkg::MODE_RUN)
        |=> (periphClkEn == $past(periphClkReg)))
        else $error("peripheral clock enables ignored software");

endmodule : power_mode_control

// [rtl/power_mode_pkg.sv]
// Constants, types and register map of the power-mode controller.
// Function
// - Setting idle select halts the core and enters idle after the writing instruction.
// - In idle clocks and peripherals keep running and all state is kept.
// - An enabled interrupt or a reset ends idle; the interrupt clears idle select.
// - After interrupt wake-up the core resumes without reset, continuing its program.
// - A reset ending idle or stop runs the reset sequence, restarting at zero.
// - An enabled watchdog timeout during idle resets the device and ends idle.
// - Setting stop select enters stop after the writing instruction completes.
// - Stop halts oscillator, core, digital peripherals, interrupts and timers.
// - Only an internal or external reset ends stop; interrupts never do.
// - An enabled clock-loss detector reset ends stop; software disables it for long stops.
// - Regulator configuration clear keeps every enabled reset source able to end stop.
// - Regulator configuration set leaves only the external reset pin to end stop.
// - Power control bits seven to two are plain read/write flags, reset zero.
// - Stop select and idle select always read back as zero; the status register shows idle select in bit two and stop select in bit three.
// - Clocks of unused digital peripherals are gated off.
// - Regulator configuration is read/write bit three; other bits read zero.
package power_mode_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int NUM_IRQ = 8;
    localparam int NUM_PERIPH = 8;

    localparam logic [ADDR_W-1:0] OFS_POWER_MODE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_REGULATOR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PERIPH_CLK = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;

    localparam int IDLE_BIT = 0;
    localparam int STOP_BIT = 1;
    localparam int FLAGS_LSB = 2;
    localparam int FLAGS_W = 6;
    localparam int STOP_REGULATOR_CFG_BIT = 3;

    localparam logic [FLAGS_W-1:0] FLAGS_RESET = 6'h00;
    localparam logic STOP_REGULATOR_CFG_RESET = 1'b0;
    localparam logic [NUM_PERIPH-1:0] PERIPH_CLK_RESET = 8'hFF;
    localparam logic [15:0] RESTART_ADDR = 16'h0000;

    localparam int CLK_PERIOD_NS = 4;
    localparam int RESET_SEQ_NS = 40;
    localparam int RESET_SEQ_CYCLES = (RESET_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    typedef enum logic [1:0] {
        MODE_RUN = 2'b00,
        MODE_IDLE = 2'b01,
        MODE_STOP = 2'b10,
        MODE_RESET = 2'b11
    } mode_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic extPin;
        logic watchdog;
        logic clockLoss;
        logic other;
    } reset_src_t;

endpackage : power_mode_pkg

// [rtl/wake_qualify.sv]
// Qualifies wake-up and reset requests against the current power mode.
`timescale 1ns/100ps
module wake_qualify (
    // Interrupt requests
    input wire logic [power_mode_pkg::NUM_IRQ-1:0] intPending,
    input wire logic [power_mode_pkg::NUM_IRQ-1:0] intEnable,
    // Reset sources and mode
    input wire power_mode_pkg::reset_src_t resetSrc,
    input wire logic inStop,
    input wire logic stopRegulatorCfg,
    // Qualified requests
    output logic wakeReq,
    output logic resetHit
);

    always_comb begin
        // Priority levels play no part in waking the core.
        wakeReq = |(intPending & intEnable);
        if (inStop && stopRegulatorCfg) begin
            // The reset network is unpowered, so only the pin can reach the core.
            resetHit = resetSrc.extPin;
        end else begin
            resetHit = |resetSrc;
        end
    end

endmodule : wake_qualify
